// >>> hdl/bse_pkg.sv
// Package for the bridge system error reporting block: register map, fields and timing.
package bse_pkg;

  // Register indices; one printed offset is not word aligned, so each index names one 32-bit word.
  localparam logic [7:0] IDX_ENABLES = 8'h90;
  localparam logic [7:0] IDX_FLAGS   = 8'h92;
  // Indices of our own: the global enable and the interrupt status and mask.
  localparam logic [7:0] IDX_GLOBAL  = 8'h94;
  localparam logic [7:0] IDX_IRQ_STS = 8'h98;
  localparam logic [7:0] IDX_IRQ_MSK = 8'h9C;

  // Byte addresses on the register bus are four times the index.
  localparam logic [9:0] ADDR_ENABLES = {IDX_ENABLES, 2'b00};
  localparam logic [9:0] ADDR_FLAGS   = {IDX_FLAGS, 2'b00};
  localparam logic [9:0] ADDR_GLOBAL  = {IDX_GLOBAL, 2'b00};
  localparam logic [9:0] ADDR_IRQ_STS = {IDX_IRQ_STS, 2'b00};
  localparam logic [9:0] ADDR_IRQ_MSK = {IDX_IRQ_MSK, 2'b00};

  // Field positions; timeout and abort are shared by enables and flags, BIT_GLOBAL is in the global enable register.
  localparam int BIT_TIMEOUT = 1;
  localparam int BIT_ABORT   = 2;
  localparam int BIT_GLOBAL  = 0;

  // Valid bit masks of the 8-bit registers.
  localparam logic [7:0] CAUSE_MASK = 8'h06;

  // Reset values.
  localparam logic [7:0] RST_ENABLES = 8'h00;
  localparam logic [7:0] RST_FLAGS   = 8'h00;
  localparam logic       RST_GLOBAL  = 1'b0;
  localparam logic [1:0] RST_IRQ     = 2'h0;

  // Delayed transaction collect limit in sys_clk clocks.
  localparam int DT_LIMIT_CLKS = 1024;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Events raised by the bridge in one cycle.
  typedef struct packed {
    logic abort;
    logic timeout;
  } bse_evt_t;

  typedef enum logic [1:0] {
    DT_IDLE = 2'b01,
    DT_WAIT = 2'b10
  } bse_dt_state_t;

endpackage

// >>> hdl/bse_dt_timer.sv
// Delayed transaction collect timer: expires a completion left uncollected.
`timescale 1ns/1ns
`default_nettype none
module bse_dt_timer #(
  parameter int LIMIT = bse_pkg::DT_LIMIT_CLKS
) (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic dt_complete,
  input  wire logic dt_collect,
  output logic      dt_pending,
  output logic      dt_expire
);

  localparam int CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

  bse_pkg::bse_dt_state_t state_r;
  logic [CW-1:0]          count_r;

  // A collect wins over expiry in the same cycle, so no flag is raised for it.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r   <= bse_pkg::DT_IDLE;
      count_r   <= '0;
      dt_expire <= 1'b0;
    end else begin
      dt_expire <= 1'b0;
      case (state_r)
        bse_pkg::DT_IDLE: begin
          count_r <= '0;
          if (dt_complete) begin
            state_r <= bse_pkg::DT_WAIT;
          end
        end
        bse_pkg::DT_WAIT: begin
          if (dt_collect) begin
            state_r <= bse_pkg::DT_IDLE;
            count_r <= '0;
          end else if (count_r == LAST) begin
            state_r   <= bse_pkg::DT_IDLE;
            dt_expire <= 1'b1;
            count_r   <= '0;
          end else begin
            count_r <= count_r + CW'(1);
          end
        end
        default: begin
          state_r <= bse_pkg::DT_IDLE;
        end
      endcase
    end
  end

  assign dt_pending = (state_r == bse_pkg::DT_WAIT);

endmodule
`default_nettype wire

// >>> hdl/bse_top.sv
// Bridge system error reporting: cause flags, enables, timer and AXI4-Lite slave.
// Functional notes
// - Abort flag with enables raises system error.
// - Timeout flag with enables raises system error.
// - Received target abort sets abort flag.
// - Uncollected completion expires after 1024 clocks.
// - Expiry discards transaction and sets timeout flag.
// - Flags clear only by writing one.
// - Global enable gates every system error.
// - System error is internal signal for NMI/SMI.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module bse_top #(
  parameter int DT_LIMIT = bse_pkg::DT_LIMIT_CLKS
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        target_abort,
  input  wire logic        dt_complete,
  input  wire logic        dt_collect,
  output logic             dt_pending,
  output logic             sys_err,
  output logic             irq,
  input  wire logic [9:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [9:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // Returns true if the address hits a mapped register.
  function automatic logic addr_hit(input logic [9:0] a);
    addr_hit = (a == bse_pkg::ADDR_ENABLES) || (a == bse_pkg::ADDR_FLAGS) ||
               (a == bse_pkg::ADDR_GLOBAL) || (a == bse_pkg::ADDR_IRQ_STS) ||
               (a == bse_pkg::ADDR_IRQ_MSK);
  endfunction

  logic [7:0]        error_response_enables_r;
  logic [7:0]        error_cause_flags_r;
  logic              global_system_error_enable_r;
  logic [1:0]        irq_sts_r;
  logic [1:0]        irq_msk_r;
  logic              abort_sync1_r;
  logic              abort_sync2_r;
  logic              complete_sync1_r;
  logic              complete_sync2_r;
  logic              collect_sync1_r;
  logic              collect_sync2_r;
  logic              dt_pending_w;
  bse_pkg::bse_evt_t evt;
  logic              timeout_w;

  logic [9:0]  aw_addr_r;
  logic        aw_have_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        w_have_r;
  logic        wr_go;
  logic [7:0]  wr_clear;
  logic        aw_have_nxt;
  logic        w_have_nxt;
  logic        bvalid_nxt;
  logic        rvalid_nxt;
  logic        wr_lane0;
  logic        wsel_enables;
  logic        wsel_flags;
  logic        wsel_global;
  logic        wsel_irq_sts;
  logic        wsel_irq_msk;

  // Event pins come from PCI-side logic outside this domain, so they are synchronised first.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      abort_sync1_r    <= 1'b0;
      abort_sync2_r    <= 1'b0;
      complete_sync1_r <= 1'b0;
      complete_sync2_r <= 1'b0;
      collect_sync1_r  <= 1'b0;
      collect_sync2_r  <= 1'b0;
    end else begin
      abort_sync1_r    <= target_abort;
      abort_sync2_r    <= abort_sync1_r;
      complete_sync1_r <= dt_complete;
      complete_sync2_r <= complete_sync1_r;
      collect_sync1_r  <= dt_collect;
      collect_sync2_r  <= collect_sync1_r;
    end
  end

  // The timer sees synchronised strobes, so a completion reaches it two clocks after its pin and is armed on the third.
  bse_dt_timer #(
    .LIMIT (DT_LIMIT)
  ) u_timer (
    .sys_clk     (sys_clk),
    .rst_b       (rst_b),
    .dt_complete (complete_sync2_r),
    .dt_collect  (collect_sync2_r),
    .dt_pending  (dt_pending_w),
    .dt_expire   (timeout_w)
  );

  assign evt = '{abort: abort_sync2_r, timeout: timeout_w};

  // Write channel capture: address and data may arrive in either order.
  // Ready is registered from next-state terms, so the port is flop driven yet never a cycle late.
  assign wr_go       = aw_have_r && w_have_r && !s_axi_bvalid;
  assign aw_have_nxt = (s_axi_awvalid && s_axi_awready) || (aw_have_r && !wr_go);
  assign w_have_nxt  = (s_axi_wvalid && s_axi_wready) || (w_have_r && !wr_go);
  assign bvalid_nxt  = wr_go || (s_axi_bvalid && !s_axi_bready);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
    end else begin
      s_axi_awready <= !aw_have_nxt && !bvalid_nxt;
      s_axi_wready  <= !w_have_nxt && !bvalid_nxt;
    end
  end

  // Per-register write selects; only byte lane 0 carries data, other lanes are ignored.
  assign wr_lane0     = wr_go && w_strb_r[0];
  assign wsel_enables = wr_lane0 && (aw_addr_r == bse_pkg::ADDR_ENABLES);
  assign wsel_flags   = wr_lane0 && (aw_addr_r == bse_pkg::ADDR_FLAGS);
  assign wsel_global  = wr_lane0 && (aw_addr_r == bse_pkg::ADDR_GLOBAL);
  assign wsel_irq_sts = wr_lane0 && (aw_addr_r == bse_pkg::ADDR_IRQ_STS);
  assign wsel_irq_msk = wr_lane0 && (aw_addr_r == bse_pkg::ADDR_IRQ_MSK);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= 10'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_have_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      w_have_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (wr_go) begin
      w_have_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= bse_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= addr_hit(aw_addr_r) ? bse_pkg::RESP_OKAY : bse_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Enable registers; reserved enable bits are dropped so they always read zero.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      error_response_enables_r <= bse_pkg::RST_ENABLES;
    end else if (wsel_enables) begin
      error_response_enables_r <= w_data_r[7:0] & bse_pkg::CAUSE_MASK;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      global_system_error_enable_r <= bse_pkg::RST_GLOBAL;
    end else if (wsel_global) begin
      global_system_error_enable_r <= w_data_r[bse_pkg::BIT_GLOBAL];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_msk_r <= bse_pkg::RST_IRQ;
    end else if (wsel_irq_msk) begin
      irq_msk_r <= w_data_r[1:0];
    end
  end

  assign wr_clear = wsel_flags ? (w_data_r[7:0] & bse_pkg::CAUSE_MASK) : 8'h00;

  // A new event wins over a write-one clear in the same cycle.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      error_cause_flags_r <= bse_pkg::RST_FLAGS;
    end else begin
      error_cause_flags_r[bse_pkg::BIT_ABORT] <= evt.abort ||
        (error_cause_flags_r[bse_pkg::BIT_ABORT] && !wr_clear[bse_pkg::BIT_ABORT]);
      error_cause_flags_r[bse_pkg::BIT_TIMEOUT] <= evt.timeout ||
        (error_cause_flags_r[bse_pkg::BIT_TIMEOUT] && !wr_clear[bse_pkg::BIT_TIMEOUT]);
    end
  end

  // Interrupt status: bit 0 abort, bit 1 timeout events, write one to clear.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_sts_r <= bse_pkg::RST_IRQ;
    end else if (wsel_irq_sts) begin
      irq_sts_r <= {evt.timeout, evt.abort} | (irq_sts_r & ~w_data_r[1:0]);
    end else begin
      irq_sts_r <= {evt.timeout, evt.abort} | irq_sts_r;
    end
  end

  // Level interrupt: stays high while any unmasked status bit is set.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_sts_r & irq_msk_r);
    end
  end

  // Internal system error, handed on for NMI or SMI routing.
  // A cause flag left set keeps the error up until software clears it or drops an enable.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sys_err <= 1'b0;
    end else begin
      sys_err <= global_system_error_enable_r && (
        (error_response_enables_r[bse_pkg::BIT_ABORT] &&
         error_cause_flags_r[bse_pkg::BIT_ABORT]) ||
        (error_response_enables_r[bse_pkg::BIT_TIMEOUT] &&
         error_cause_flags_r[bse_pkg::BIT_TIMEOUT]));
    end
  end

  // Pending is registered once more so the port is flop driven; it trails the timer by a clock.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dt_pending <= 1'b0;
    end else begin
      dt_pending <= dt_pending_w;
    end
  end

  // Read mux; unmapped addresses read as zero so nothing leaks with an error answer.
  function automatic logic [31:0] read_word(input logic [9:0] a);
    read_word = 32'h0000_0000;
    if (a == bse_pkg::ADDR_ENABLES) begin
      read_word = {24'h000000, error_response_enables_r};
    end else if (a == bse_pkg::ADDR_FLAGS) begin
      read_word = {24'h000000, error_cause_flags_r};
    end else if (a == bse_pkg::ADDR_GLOBAL) begin
      read_word = {31'h0000_0000, global_system_error_enable_r};
    end else if (a == bse_pkg::ADDR_IRQ_STS) begin
      read_word = {30'h0000_0000, irq_sts_r};
    end else if (a == bse_pkg::ADDR_IRQ_MSK) begin
      read_word = {30'h0000_0000, irq_msk_r};
    end
  endfunction

  // Read channel: one read at a time, answered the cycle after the address is taken.
  assign rvalid_nxt = (s_axi_arvalid && s_axi_arready) || (s_axi_rvalid && !s_axi_rready);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b1;
    end else begin
      s_axi_arready <= !rvalid_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= bse_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= addr_hit(s_axi_araddr) ? bse_pkg::RESP_OKAY : bse_pkg::RESP_SLVERR;
      s_axi_rdata  <= read_word(s_axi_araddr);
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// >>> dv/bse_monitor.sv
// Checker on the ports of the bridge system error reporting block.
`timescale 1ns/1ns
`default_nettype none
module bse_monitor #(
  parameter int DT_LIMIT = 1024
) (
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        target_abort,
  input wire logic        dt_complete,
  input wire logic        dt_pending,
  input wire logic        sys_err,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  int pend_cnt;
  int since_cause;
  int since_wr;
  // since_cause and since_wr saturate at 100 so that a long quiet stretch never wraps into a false pass; pend_cnt does not saturate.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) pend_cnt <= 0;
    else if (dt_complete || !dt_pending) pend_cnt <= 0;
    else pend_cnt <= pend_cnt + 1;
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) since_cause <= 100;
    else if (target_abort || $fell(dt_pending) || (s_axi_awvalid && s_axi_awready)) since_cause <= 0;
    else if (since_cause < 100) since_cause <= since_cause + 1;
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) since_wr <= 100;
    else if (s_axi_awvalid && s_axi_awready) since_wr <= 0;
    else if (since_wr < 100) since_wr <= since_wr + 1;
  end
  pend_bound_a: assert property (pend_cnt <= DT_LIMIT + 6)
    else $error("pending completion outlived its collect limit");
  err_cause_a: assert property ($rose(sys_err) |-> since_cause <= 6)
    else $error("system error rose with no recent cause");
  err_sticky_a: assert property ($fell(sys_err) |-> since_wr <= 6)
    else $error("system error fell with no register write");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response withdrawn early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data withdrawn or changed early");
  r_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  slverr_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h00000000)
    else $error("error read returned data");
  ar_stall_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while a read is open");
  aw_stall_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while a response is open");
  cover property ($rose(sys_err));
  cover property ($fell(dt_pending) && !dt_complete);
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule
`default_nettype wire

// >>> dv/bse_pci_side.sv
// Model of the bus agents behind the bridge that raise aborts, completions and collects.
`timescale 1ns/1ns
`default_nettype none
module bse_pci_side (
  input  wire logic sys_clk,
  output wire logic target_abort,
  output wire logic dt_complete,
  output wire logic dt_collect
);
  logic [2:0] ev = 3'h0;
  assign {target_abort, dt_complete, dt_collect} = ev;
  // A slow agent waits before acting; each event lasts one clock.
  task automatic pulse(input logic [2:0] sel, input int lag);
    repeat (lag) @(posedge sys_clk);
    ev <= sel;
    @(posedge sys_clk);
    ev <= 3'h0;
  endtask
endmodule
`default_nettype wire

// >>> dv/bse_tb_top.sv
// Self-checking testbench for the bridge system error reporting block.
`timescale 1ns/1ns
`default_nettype none
module bse_tb_top;
  localparam int LIM = 8;
  logic        sys_clk, rst_b, target_abort, dt_complete, dt_collect, dt_pending, sys_err, irq;
  logic [9:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          err_total, comparisons;
  bse_top #(.DT_LIMIT(LIM)) dut (.sys_clk, .rst_b, .target_abort, .dt_complete, .dt_collect, .dt_pending,
    .sys_err, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  bse_pci_side u_pci (.sys_clk, .target_abort, .dt_complete, .dt_collect);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Ready, valid and payload are looked at mid-cycle, where they stand settled for the coming edge.
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic aw_d, w_d, aw_t, w_t, b_t;
    logic [1:0] rsp;
    aw_d = 1'b0;
    w_d = 1'b0;
    b_t = 1'b0;
    rsp = 2'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_d && w_d)) begin
      @(negedge sys_clk);
      aw_t = !aw_d && s_axi_awready;
      w_t = !w_d && s_axi_wready;
      @(posedge sys_clk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
      aw_d = aw_d | aw_t;
      w_d = w_d | w_t;
    end
    while (b_t !== 1'b1) begin
      @(negedge sys_clk);
      b_t = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge sys_clk);
    end
    chk("bresp", {30'h0, bse_pkg::RESP_OKAY}, {30'h0, rsp});
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rchk(input logic [9:0] a, input logic [31:0] e, input logic [1:0] er);
    logic a_t, r_t;
    logic [31:0] dat;
    logic [1:0] rsp;
    a_t = 1'b0;
    r_t = 1'b0;
    dat = 32'h0;
    rsp = 2'h0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (a_t !== 1'b1) begin
      @(negedge sys_clk);
      a_t = s_axi_arready;
      @(posedge sys_clk);
    end
    s_axi_arvalid <= 1'b0;
    while (r_t !== 1'b1) begin
      @(negedge sys_clk);
      r_t = s_axi_rvalid;
      dat = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge sys_clk);
    end
    chk("rdata", e, dat);
    chk("rresp", {30'h0, er}, {30'h0, rsp});
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  initial begin
    rst_b = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 52'h0;
    s_axi_wstrb = 4'hF;
    idle(20);
    rst_b <= 1'b1;
    idle(1);
    rchk(bse_pkg::ADDR_ENABLES, 32'h00000000, bse_pkg::RESP_OKAY);
    rchk(bse_pkg::ADDR_FLAGS, 32'h00000000, bse_pkg::RESP_OKAY);
    rchk(bse_pkg::ADDR_GLOBAL, 32'h00000000, bse_pkg::RESP_OKAY);
    rchk(10'h3FC, 32'h00000000, bse_pkg::RESP_SLVERR);
    s_axi_wstrb <= 4'hE;
    wr(bse_pkg::ADDR_ENABLES, 32'h000000FF);
    s_axi_wstrb <= 4'hF;
    rchk(bse_pkg::ADDR_ENABLES, 32'h00000000, bse_pkg::RESP_OKAY);
    wr(bse_pkg::ADDR_ENABLES, 32'h000000FF);
    rchk(bse_pkg::ADDR_ENABLES, 32'h00000006, bse_pkg::RESP_OKAY);
    wr(bse_pkg::ADDR_IRQ_MSK, 32'h00000003);
    u_pci.pulse(3'h4, 2);
    idle(6);
    rchk(bse_pkg::ADDR_FLAGS, 32'h00000004, bse_pkg::RESP_OKAY);
    chk("sys_err", 32'h0, {31'h0, sys_err});
    chk("irq", 32'h1, {31'h0, irq});
    wr(bse_pkg::ADDR_GLOBAL, 32'h00000001);
    idle(4);
    chk("sys_err", 32'h1, {31'h0, sys_err});
    wr(bse_pkg::ADDR_FLAGS, 32'h00000000);
    rchk(bse_pkg::ADDR_FLAGS, 32'h00000004, bse_pkg::RESP_OKAY);
    wr(bse_pkg::ADDR_FLAGS, 32'h00000004);
    idle(4);
    rchk(bse_pkg::ADDR_FLAGS, 32'h00000000, bse_pkg::RESP_OKAY);
    chk("sys_err", 32'h0, {31'h0, sys_err});
    wr(bse_pkg::ADDR_IRQ_STS, 32'h00000001);
    idle(3);
    chk("irq", 32'h0, {31'h0, irq});
    u_pci.pulse(3'h2, 0);
    idle(4);
    chk("dt_pending", 32'h1, {31'h0, dt_pending});
    idle(LIM - 2);
    chk("dt_pending", 32'h1, {31'h0, dt_pending});
    idle(2);
    chk("dt_pending", 32'h0, {31'h0, dt_pending});
    rchk(bse_pkg::ADDR_FLAGS, 32'h00000002, bse_pkg::RESP_OKAY);
    chk("sys_err", 32'h1, {31'h0, sys_err});
    wr(bse_pkg::ADDR_ENABLES, 32'h00000004);
    idle(3);
    chk("sys_err", 32'h0, {31'h0, sys_err});
    wr(bse_pkg::ADDR_FLAGS, 32'h00000002);
    u_pci.pulse(3'h2, 0);
    u_pci.pulse(3'h1, 3);
    idle(LIM + 10);
    rchk(bse_pkg::ADDR_FLAGS, 32'h00000000, bse_pkg::RESP_OKAY);
    chk("dt_pending", 32'h0, {31'h0, dt_pending});
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    wrap_up();
  end
endmodule
bind bse_top bse_monitor #(.DT_LIMIT(DT_LIMIT)) u_mon (.sys_clk, .rst_b, .target_abort, .dt_complete,
  .dt_pending, .sys_err, .s_axi_awvalid, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
`default_nettype wire
